// ===== rtl/canfc_pkg.sv
// Purpose: shared constants and carriers of the can fault supervisor
// Assumes: 20 MHz core clock, active high asynchronous reset
// Notes:   all timing figures are given in ns and turned into cycle counts here
// Operation
// - low means dominant, high means recessive
// - bus stays recessive until reset pin seen
// - any supervised fault sets the error flag
// - disable bit suppresses every fault handling action
// - transmit stuck low disables transmitter, latches
// - bus missing dominant four times disables transmitter
// - host reads, clears flags; disable holds till clear
// - bus dominant too long latches, transmitter stays
// - echo missing four times disables transmitter, latches
package canfc_pkg;

  localparam int unsigned CLK_PERIOD_NS = 50;

  // counter geometry
  localparam int unsigned CNT_W  = 20;
  localparam int unsigned WIN_W  = 8;
  localparam int unsigned MISS_W = 3;

  // timing figures in ns
  localparam int unsigned TX_DOM_TIMEOUT_NS = 1000000;
  localparam int unsigned BUS_DOM_TIMEOUT_NS = 1000000;
  localparam int unsigned ECHO_WINDOW_NS    = 600;

  // derived cycle counts, least times rounded up
  localparam logic [CNT_W-1:0] TX_DOM_CYC =
    CNT_W'((TX_DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] BUS_DOM_CYC =
    CNT_W'((BUS_DOM_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [WIN_W-1:0] ECHO_WIN_CYC =
    WIN_W'((ECHO_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [MISS_W-1:0] ECHO_MISS_LIMIT = 3'h4;

  // event fifo geometry
  localparam int unsigned EVT_W     = 4;
  localparam int unsigned EVT_DEPTH = 16;

  // reset values
  localparam logic [2:0] RST_SYNC_HIGH = 3'h7;
  localparam logic [2:0] RST_SYNC_LOW  = 3'h0;

  // latched fault flags, also the clear strobe layout and event word layout
  typedef struct packed {
    logic perm_dom;      // bus dominant too long
    logic echo_loss;     // internal echo did not follow
    logic rx_recessive;  // bus did not follow
    logic tx_timeout;    // transmit input stuck dominant
  } canfc_flags_t;

  localparam canfc_flags_t RST_FLAGS = 4'h0;

  // complete state of the supervisor
  typedef struct packed {
    logic [2:0]        tx_sync;
    logic [2:0]        bus_sync;
    logic [2:0]        echo_sync;
    logic [2:0]        rstp_sync;
    logic              tx_f;
    logic              bus_f;
    logic              echo_f;
    logic              rstp_f;
    logic              tx_prev;
    logic              armed;
    logic              bus_drive;
    logic              rx_out;
    logic [CNT_W-1:0]  dom_cnt;
    logic [CNT_W-1:0]  perm_cnt;
    logic [WIN_W-1:0]  win_cnt;
    logic              seen_bus;
    logic              seen_echo;
    logic [MISS_W-1:0] miss_bus;
    logic [MISS_W-1:0] miss_echo;
    canfc_flags_t      flags;
    logic [EVT_W-1:0]  pend;
  } canfc_state_t;

endpackage : canfc_pkg

// ===== rtl/canfc_fifo.sv
// Purpose: event queue between the supervisor and the host link
// Assumes: single clock, depth a power of two
// Notes:   data out is the stored word, so it comes straight from flops
`timescale 1ns/10ps
`default_nettype none
module canfc_fifo #(
  parameter int unsigned WIDTH = 4,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } canfc_fifo_state_t;

  canfc_fifo_state_t st_ff;
  canfc_fifo_state_t nxt_st;
  logic              push;
  logic              pop;

  // honest full and empty from the fill count
  assign in_ready  = (st_ff.count != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.count != '0);
  assign out_data  = st_ff.mem[st_ff.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // pointer and count update; wrap is natural for a power of two depth
  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr            = st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = st_ff.rd + 1'b1;
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 1'b1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : canfc_fifo
`default_nettype wire

// ===== rtl/canfc_top.sv
// Purpose: fault supervision and level mapping around a high speed can transceiver
// Assumes: pins are asynchronous and pass a three flop filter; clears are core pulses
// Notes:   fault flags and transmitter disable survive until the host clears them
`timescale 1ns/10ps
`default_nettype none
module canfc_top #(
  parameter logic [canfc_pkg::CNT_W-1:0]  DOM_TX_CYCLES   = canfc_pkg::TX_DOM_CYC,
  parameter logic [canfc_pkg::CNT_W-1:0]  PERM_DOM_CYCLES = canfc_pkg::BUS_DOM_CYC,
  parameter logic [canfc_pkg::WIN_W-1:0]  ECHO_WIN_CYCLES = canfc_pkg::ECHO_WIN_CYC,
  parameter logic [canfc_pkg::MISS_W-1:0] MISS_LIMIT      = canfc_pkg::ECHO_MISS_LIMIT,
  parameter int unsigned                  EVT_DEPTH       = canfc_pkg::EVT_DEPTH
) (
  input  wire logic                             clock,
  input  wire logic                             rst,
  input  wire logic                             tx_pin,
  input  wire logic                             bus_rx,
  input  wire logic                             rx_echo,
  input  wire logic                             reset_pin,
  input  wire logic                             fault_handling_disable,
  input  wire canfc_pkg::canfc_flags_t          fault_clear,
  output logic                                  rx_pin,
  output logic                                  bus_drive_dominant,
  output logic                                  tx_disabled,
  output logic                                  fault_any,
  output canfc_pkg::canfc_flags_t               fault_status,
  output logic                                  evt_valid,
  input  wire logic                             evt_ready,
  output logic [canfc_pkg::EVT_W-1:0]           evt_data
);
  canfc_pkg::canfc_state_t st_ff;
  canfc_pkg::canfc_state_t nxt_st;
  canfc_pkg::canfc_flags_t set_evt;
  logic                    dis;
  logic                    tx_dom;
  logic                    bus_dom;
  logic                    txoff;
  logic                    tx_fall;
  logic                    win_end;
  logic                    miss_b;
  logic                    miss_e;
  logic                    push_valid;
  logic                    push_ready;
  logic [canfc_pkg::EVT_W-1:0] push_data;
  logic [canfc_pkg::EVT_W-1:0] new_evt;

  // a level change counts only once the second and third flops agree
  function automatic logic filt(input logic s2, input logic s3, input logic cur);
    filt = (s2 == s3) ? s3 : cur;
  endfunction : filt

  // consecutive miss counter step: returns the next count, flags the limit
  function automatic logic [canfc_pkg::MISS_W:0] miss_step(
    input logic                        miss,
    input logic [canfc_pkg::MISS_W-1:0] cnt,
    input logic [canfc_pkg::MISS_W-1:0] lim
  );
    miss_step = '0;
    if (miss) begin
      if (cnt == lim - 1'b1) begin
        miss_step = {1'b1, {canfc_pkg::MISS_W{1'b0}}};
      end else begin
        miss_step = {1'b0, cnt + 1'b1};
      end
    end
  endfunction : miss_step

  assign dis        = fault_handling_disable;
  assign tx_dom     = ~st_ff.tx_f & st_ff.armed;
  assign bus_dom    = ~st_ff.bus_f;
  assign txoff      = ~dis & (st_ff.flags.tx_timeout | st_ff.flags.rx_recessive
                              | st_ff.flags.echo_loss);
  assign tx_fall    = st_ff.tx_prev & ~st_ff.tx_f & st_ff.armed & ~txoff & ~dis;
  assign win_end    = (st_ff.win_cnt == 8'h01);
  assign miss_b     = win_end & ~(st_ff.seen_bus | bus_dom);
  assign miss_e     = win_end & ~(st_ff.seen_echo | ~st_ff.echo_f);
  assign new_evt    = set_evt & ~st_ff.flags;
  assign push_valid = (st_ff.pend != '0);
  assign push_data  = st_ff.pend & (~st_ff.pend + 4'h1);

  // outputs from state flops; fault_any is their OR, tx_disabled is also gated directly by fault_handling_disable
  assign rx_pin             = st_ff.rx_out;
  assign bus_drive_dominant = st_ff.bus_drive;
  assign tx_disabled        = txoff;
  assign fault_status       = st_ff.flags;
  assign fault_any          = |st_ff.flags;

  // next state: filters, counters, flags, event queue feed
  always_comb begin
    logic [canfc_pkg::MISS_W:0] mb;
    logic [canfc_pkg::MISS_W:0] me;
    mb      = '0;
    me      = '0;
    nxt_st  = st_ff;
    set_evt = '0;
    nxt_st.tx_sync   = {st_ff.tx_sync[1:0], tx_pin};
    nxt_st.bus_sync  = {st_ff.bus_sync[1:0], bus_rx};
    nxt_st.echo_sync = {st_ff.echo_sync[1:0], rx_echo};
    nxt_st.rstp_sync = {st_ff.rstp_sync[1:0], reset_pin};
    nxt_st.tx_f      = filt(st_ff.tx_sync[1], st_ff.tx_sync[2], st_ff.tx_f);
    nxt_st.bus_f     = filt(st_ff.bus_sync[1], st_ff.bus_sync[2], st_ff.bus_f);
    nxt_st.echo_f    = filt(st_ff.echo_sync[1], st_ff.echo_sync[2], st_ff.echo_f);
    nxt_st.rstp_f    = filt(st_ff.rstp_sync[1], st_ff.rstp_sync[2], st_ff.rstp_f);
    nxt_st.tx_prev   = st_ff.tx_f;
    // transmit input is ignored until the reset pin has been seen asserted
    if (st_ff.rstp_f) begin
      nxt_st.armed = 1'b1;
    end
    // stuck dominant transmit: count clocks while low, restart on high
    if (!tx_dom || dis) begin
      nxt_st.dom_cnt = '0;
    end else if (st_ff.dom_cnt != DOM_TX_CYCLES) begin
      nxt_st.dom_cnt = st_ff.dom_cnt + 1'b1;
    end
    set_evt.tx_timeout = ~dis & tx_dom & (st_ff.dom_cnt == DOM_TX_CYCLES);
    // permanent dominant bus: latched only, the driver keeps running
    if (!bus_dom || dis) begin
      nxt_st.perm_cnt = '0;
    end else if (st_ff.perm_cnt != PERM_DOM_CYCLES) begin
      nxt_st.perm_cnt = st_ff.perm_cnt + 1'b1;
    end
    set_evt.perm_dom = ~dis & bus_dom & (st_ff.perm_cnt == PERM_DOM_CYCLES);
    // echo window opens on each dominant edge we actually drive while no window is open
    if (st_ff.win_cnt != '0) begin
      nxt_st.win_cnt   = st_ff.win_cnt - 1'b1;
      nxt_st.seen_bus  = st_ff.seen_bus | bus_dom;
      nxt_st.seen_echo = st_ff.seen_echo | ~st_ff.echo_f;
    end else if (tx_fall) begin
      nxt_st.win_cnt   = ECHO_WIN_CYCLES;
      nxt_st.seen_bus  = 1'b0;
      nxt_st.seen_echo = 1'b0;
    end
    // a followed edge resets the miss run, only consecutive misses count
    if (win_end) begin
      mb = miss_step(miss_b, st_ff.miss_bus, MISS_LIMIT);
      me = miss_step(miss_e, st_ff.miss_echo, MISS_LIMIT);
      nxt_st.miss_bus  = mb[canfc_pkg::MISS_W-1:0];
      nxt_st.miss_echo = me[canfc_pkg::MISS_W-1:0];
    end
    set_evt.rx_recessive = ~dis & mb[canfc_pkg::MISS_W];
    set_evt.echo_loss    = ~dis & me[canfc_pkg::MISS_W];
    if (dis) begin
      nxt_st.win_cnt   = '0;
      nxt_st.miss_bus  = '0;
      nxt_st.miss_echo = '0;
    end
    // sticky flags: a set in the clearing cycle wins
    nxt_st.flags = (st_ff.flags & ~fault_clear) | set_evt;
    // pending events wait here while the queue is full
    if (push_valid && push_ready) begin
      nxt_st.pend = (st_ff.pend & ~push_data) | new_evt;
    end else begin
      nxt_st.pend = st_ff.pend | new_evt;
    end
    // driver and receive pin, one flop after the filtered inputs
    nxt_st.bus_drive = tx_dom & ~txoff;
    nxt_st.rx_out    = st_ff.bus_f;
  end

  // reset keeps pins recessive and the device disarmed
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_ff           <= '0;
      st_ff.tx_sync   <= canfc_pkg::RST_SYNC_HIGH;
      st_ff.bus_sync  <= canfc_pkg::RST_SYNC_HIGH;
      st_ff.echo_sync <= canfc_pkg::RST_SYNC_HIGH;
      st_ff.rstp_sync <= canfc_pkg::RST_SYNC_LOW;
      st_ff.tx_f      <= 1'b1;
      st_ff.bus_f     <= 1'b1;
      st_ff.echo_f    <= 1'b1;
      st_ff.tx_prev   <= 1'b1;
      st_ff.rx_out    <= 1'b1;
      st_ff.flags     <= canfc_pkg::RST_FLAGS;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // fault events queued toward the host link
  canfc_fifo #(
    .WIDTH (canfc_pkg::EVT_W),
    .DEPTH (EVT_DEPTH)
  ) u_evt_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (evt_valid),
    .out_ready (evt_ready),
    .out_data  (evt_data)
  );

  // a driven dominant edge and the end of its echo window
  sequence s_drive_fall;
    tx_fall && (st_ff.win_cnt == '0);
  endsequence

  sequence s_win_close;
    win_end && !dis;
  endsequence

  property p_drive_map;
    @(posedge clock) disable iff (rst)
    bus_drive_dominant |-> ($past(st_ff.tx_f) == 1'b0) && $past(st_ff.armed);
  endproperty
  a_drive_map: assert property (p_drive_map) else $error("dominant drive without low tx");

  property p_rx_map;
    @(posedge clock) disable iff (rst)
    rx_pin == $past(st_ff.bus_f);
  endproperty
  a_rx_map: assert property (p_rx_map) else $error("rx pin does not follow bus");

  property p_unarmed;
    @(posedge clock) disable iff (rst)
    !st_ff.armed |=> !bus_drive_dominant;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("driving before reset pin seen");

  property p_any;
    @(posedge clock) disable iff (rst)
    (set_evt != '0) |=> fault_any;
  endproperty
  a_any: assert property (p_any) else $error("error flag not set on fault");

  property p_disable;
    @(posedge clock) disable iff (rst)
    dis ##1 dis |-> !$rose(|fault_status) && !tx_disabled;
  endproperty
  a_disable: assert property (p_disable) else $error("fault action while disabled");

  property p_tx_timeout;
    @(posedge clock) disable iff (rst)
    (tx_dom && !dis && st_ff.dom_cnt == DOM_TX_CYCLES)
      |=> fault_status.tx_timeout ##1 !bus_drive_dominant || dis;
  endproperty
  a_tx_timeout: assert property (p_tx_timeout) else $error("tx timeout not handled");

  property p_bus_miss;
    @(posedge clock) disable iff (rst)
    s_win_close ##0 (miss_b && st_ff.miss_bus == MISS_LIMIT - 1'b1)
      |=> fault_status.rx_recessive;
  endproperty
  a_bus_miss: assert property (p_bus_miss) else $error("bus miss limit not latched");

  property p_hold;
    @(posedge clock) disable iff (rst)
    (fault_status.tx_timeout && !fault_clear.tx_timeout && !dis)
      |=> fault_status.tx_timeout && tx_disabled;
  endproperty
  a_hold: assert property (p_hold) else $error("tx disable released without clear");

  property p_perm;
    @(posedge clock) disable iff (rst)
    (fault_status == canfc_pkg::canfc_flags_t'(4'h8)) |-> !tx_disabled;
  endproperty
  a_perm: assert property (p_perm) else $error("permanent dominant disabled tx");

  property p_echo_miss;
    @(posedge clock) disable iff (rst)
    s_win_close ##0 (miss_e && st_ff.miss_echo == MISS_LIMIT - 1'b1)
      |=> fault_status.echo_loss ##1 tx_disabled || dis;
  endproperty
  a_echo_miss: assert property (p_echo_miss) else $error("echo miss limit not latched");

  property p_window;
    @(posedge clock) disable iff (rst)
    s_drive_fall |=> (st_ff.win_cnt == ECHO_WIN_CYCLES);
  endproperty
  a_window: assert property (p_window) else $error("echo window not opened");

  property p_restart;
    @(posedge clock) disable iff (rst)
    st_ff.tx_f |=> (st_ff.dom_cnt == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("timeout count not restarted");

  // the driver keeps running, so only the latch shows a stuck bus
  property p_perm_set;
    @(posedge clock) disable iff (rst)
    (bus_dom && !dis && st_ff.perm_cnt == PERM_DOM_CYCLES) |=> fault_status.perm_dom;
  endproperty
  a_perm_set: assert property (p_perm_set) else $error("permanent dominant not latched");

  // a clear with no fresh event must drop the flag
  property p_clear;
    @(posedge clock) disable iff (rst)
    (fault_clear.perm_dom && !set_evt.perm_dom) |=> !fault_status.perm_dom;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared by host");

  // counters parked while disabled, so no stale count fires on release
  property p_held_cnt;
    @(posedge clock) disable iff (rst)
    dis |=> (st_ff.dom_cnt == '0) && (st_ff.perm_cnt == '0);
  endproperty
  a_held_cnt: assert property (p_held_cnt) else $error("counter ran while disabled");

  // every newly set flag is kept for the host queue
  property p_evt_queued;
    @(posedge clock) disable iff (rst)
    (new_evt != '0) |=> (st_ff.pend != '0);
  endproperty
  a_evt_queued: assert property (p_evt_queued) else $error("fault event not queued");

endmodule : canfc_top
`default_nettype wire

// ===== testbench/canfc_ctrl_model.sv
// Purpose: controller side model, sends one byte on tx_pin and samples rx_pin per bit
// Assumes: msb first, every bit held BIT_CYC clocks, rx sampled in the bit's last clock
// Notes:   tx_pin idles recessive between frames, like the pin's pull-up
`timescale 1ns/10ps
`default_nettype none
module canfc_ctrl_model #(
  parameter int unsigned BIT_CYC = 12
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       start,
  input  wire logic [7:0] data,
  input  wire logic       rx_pin,
  output logic            tx_pin,
  output logic            busy,
  output logic            done,
  output logic [7:0]      got
);
  logic [7:0] sh_ff;
  logic [2:0] idx_ff;
  logic [7:0] cnt_ff;

  // bit engine; 0 is dominant, 1 recessive
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_pin <= 1'b1;
      busy   <= 1'b0;
      done   <= 1'b0;
      got    <= 8'h00;
      sh_ff  <= 8'h00;
      idx_ff <= 3'h7;
      cnt_ff <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (start) begin
          busy   <= 1'b1;
          sh_ff  <= data;
          idx_ff <= 3'h7;
          cnt_ff <= 8'h00;
          tx_pin <= data[7];
        end
      end else if (cnt_ff == 8'(BIT_CYC - 1)) begin
        got[idx_ff] <= rx_pin; // late sample leaves room for the filter delay
        cnt_ff      <= 8'h00;
        if (idx_ff == 3'h0) begin
          busy   <= 1'b0;
          done   <= 1'b1;
          tx_pin <= 1'b1;
        end else begin
          idx_ff <= idx_ff - 3'h1;
          tx_pin <= sh_ff[idx_ff - 3'h1];
        end
      end else begin
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
endmodule : canfc_ctrl_model
`default_nettype wire

// ===== testbench/tb_can_transceiver_fault_control.sv
// Purpose: self-checking bench for the can fault supervisor
// Assumes: short timeouts (40 and 60 clocks), echo window 8 clocks
// Notes:   event words and echoed bytes are checked from queues by one watcher
`timescale 1ns/10ps
`default_nettype none
module tb_can_transceiver_fault_control;
  logic clock = 1'b0;
  logic rst;
  logic reset_pin;
  logic dis;
  logic other_dom;
  logic stuck_rec;
  logic echo_stuck;
  logic evt_ready;
  logic evt_hold;
  logic start;
  logic [7:0] data;
  canfc_pkg::canfc_flags_t fault_clear;
  canfc_pkg::canfc_flags_t fault_status;
  logic tx_pin, bus_rx, rx_echo, rx_pin, bus_drive_dominant, tx_disabled, fault_any;
  logic evt_valid, busy, done;
  logic [3:0] evt_data;
  logic [7:0] got, b;
  logic [7:0] evq[$];
  logic [7:0] rxq[$];
  int mismatches = 0;
  int samples_checked = 0;
  int seed = 32'h17ec27ef;

  always #25 clock = ~clock;

  // bus and echo follow the driver unless a fault is injected; low is dominant
  assign bus_rx  = stuck_rec | ~(bus_drive_dominant | other_dom);
  assign rx_echo = echo_stuck | ~bus_drive_dominant;

  canfc_top #(.DOM_TX_CYCLES(20'h00028), .PERM_DOM_CYCLES(20'h0003C),
    .ECHO_WIN_CYCLES(8'h08)) canfc_top_i (
    .clock(clock), .rst(rst), .tx_pin(tx_pin), .bus_rx(bus_rx), .rx_echo(rx_echo),
    .reset_pin(reset_pin), .fault_handling_disable(dis), .fault_clear(fault_clear),
    .rx_pin(rx_pin), .bus_drive_dominant(bus_drive_dominant), .tx_disabled(tx_disabled),
    .fault_any(fault_any), .fault_status(fault_status), .evt_valid(evt_valid),
    .evt_ready(evt_ready), .evt_data(evt_data));

  canfc_ctrl_model canfc_ctrl_model_i (
    .clock(clock), .rst(rst), .start(start), .data(data), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .busy(busy), .done(done), .got(got));

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // the host pops at random, and never while evt_hold stalls it
  always @(negedge clock) evt_ready <= evt_hold ? 1'b0 : 1'($random(seed));

  // watcher: oldest note against each result as it appears
  always @(posedge clock) begin
    if (evt_valid === 1'b1 && evt_ready) begin
      if (evq.size() == 0) check("stray event", {4'h0, evt_data}, 8'h00);
      else check("event", {4'h0, evt_data}, evq.pop_front());
    end
    if (done === 1'b1) begin
      if (rxq.size() == 0) check("stray byte", got, 8'h00);
      else check("echo byte", got, rxq.pop_front());
    end
  end

  task automatic send(input logic [7:0] d, input logic [7:0] exp);
    int i;
    rxq.push_back(exp);
    @(negedge clock);
    data  = d;
    start = 1'b1;
    @(negedge clock);
    start = 1'b0;
    for (i = 0; i < 200 && busy; i++) @(negedge clock);
    repeat (3) @(negedge clock);
  endtask : send

  task automatic stat(input logic [3:0] fl, input logic dis_exp);
    check("fault_status", {4'h0, fault_status}, {4'h0, fl});
    check("tx_disabled", {7'h0, tx_disabled}, {7'h0, dis_exp});
    check("fault_any", {7'h0, fault_any}, {7'h0, |fl});
  endtask : stat

  task automatic clear(input logic [3:0] fl);
    @(negedge clock);
    fault_clear = fl;
    @(negedge clock);
    fault_clear = 4'h0;
    repeat (2) @(negedge clock);
  endtask : clear

  task automatic hold_dom(input int n);
    other_dom = 1'b1;
    repeat (n) @(negedge clock);
    other_dom = 1'b0;
    repeat (8) @(negedge clock);
  endtask : hold_dom

  task automatic end_test(input string name);
    int i;
    for (i = 0; i < 600 && (evq.size() != 0 || rxq.size() != 0); i++) @(negedge clock);
    if (evq.size() != 0 || rxq.size() != 0) check("queues drained", 8'h01, 8'h00);
    $display("test %s done", name);
  endtask : end_test

  task automatic conclude;
    $display("compares %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  initial begin
    #(50 * 20000);
    mismatches++;
    conclude();
  end

  initial begin
    int k;
    rst         = 1'b1;
    reset_pin   = 1'b0;
    dis         = 1'b0;
    other_dom   = 1'b0;
    stuck_rec   = 1'b0;
    echo_stuck  = 1'b0;
    evt_hold    = 1'b0;
    start       = 1'b0;
    data        = 8'h00;
    fault_clear = 4'h0;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    send(8'hA5, 8'hFF);
    stat(4'h0, 1'b0);
    end_test("unarmed");
    reset_pin = 1'b1;
    repeat (6) @(negedge clock);
    reset_pin = 1'b0; // arming is sticky
    // lows of 12 clocks with highs between: the count must restart each time
    for (k = 0; k < 3; k++) begin
      b = 8'($random(seed)) | 8'h55;
      send(b, b);
    end
    stat(4'h0, 1'b0);
    end_test("echo");
    evq.push_back(8'h01);
    send(8'h00, 8'h0F);
    stat(4'h1, 1'b1);
    send(8'h55, 8'hFF);
    clear(4'h1);
    stat(4'h0, 1'b0);
    send(8'h55, 8'h55);
    end_test("tx timeout");
    dis = 1'b1;
    send(8'h00, 8'h00);
    hold_dom(90);
    stat(4'h0, 1'b0);
    dis = 1'b0;
    end_test("disable");
    evq.push_back(8'h08);
    hold_dom(70);
    stat(4'h8, 1'b0);
    clear(4'h8);
    end_test("permanent dominant");
    stuck_rec = 1'b1;
    evq.push_back(8'h02);
    send(8'h55, 8'hFF);
    stat(4'h2, 1'b1);
    stuck_rec = 1'b0;
    clear(4'h2);
    end_test("bus recessive");
    echo_stuck = 1'b1;
    evq.push_back(8'h04);
    send(8'h55, 8'h55);
    stat(4'h4, 1'b1);
    echo_stuck = 1'b0;
    clear(4'h4);
    stat(4'h0, 1'b0);
    end_test("echo loss");
    // seventeen events with the host stalled: sixteen fill, one waits pending
    evt_hold = 1'b1;
    for (k = 0; k < 17; k++) begin
      evq.push_back(8'h08);
      hold_dom(70);
      clear(4'h8);
    end
    check("evt_valid full", {7'h0, evt_valid}, 8'h01);
    evt_hold = 1'b0;
    end_test("event queue");
    check("evt_valid empty", {7'h0, evt_valid}, 8'h00);
    conclude();
  end
endmodule : tb_can_transceiver_fault_control
`default_nettype wire
